// ### wis_pkg.sv
// constants, field layouts and carrier types for the wan overhead port and test patterns
package wis_pkg;

	// clock rates and overhead clock divider
	localparam int         CLK_FREQ_KHZ = 100000;
	localparam int         OH_FREQ_KHZ  = 19440;
	localparam int         OH_DIV       = CLK_FREQ_KHZ / OH_FREQ_KHZ;
	localparam logic [2:0] OH_DIV_LAST  = 3'(OH_DIV - 1);
	localparam logic [2:0] OH_RISE_CNT  = 3'(OH_DIV / 2);

	// overhead frame layout, in 10-bit slots (stuff bit plus 9-bit word)
	localparam logic [7:0] OH_SLOTS       = 8'hF3;
	localparam int         OH_STORED      = 231;
	localparam logic [7:0] OH_STORED_IDX  = 8'hE7;
	localparam logic [7:0] LINE_BIP_FIRST = 8'h11;
	localparam logic [7:0] LINE_BIP_LAST  = 8'hD0;
	localparam logic [7:0] REI_STS1_IDX   = 8'hE3;
	localparam logic [7:0] REI_STSN_IDX   = 8'hE4;
	localparam logic [3:0] OH_LAST_BIT    = 4'h9;

	// register byte offsets
	localparam logic [7:0] OFF_CTRL      = 8'h00;
	localparam logic [7:0] OFF_TXCTRL    = 8'h04;
	localparam logic [7:0] OFF_STAT2     = 8'h08;
	localparam logic [7:0] OFF_SECTION_BIP_ERROR_COUNT    = 8'h0C;
	localparam logic [7:0] OFF_B2_CNT    = 8'h10;
	localparam logic [7:0] OFF_B3_CNT    = 8'h14;
	localparam logic [7:0] OFF_PRBS_CNT  = 8'h18;
	localparam logic [7:0] OFF_PRBS_STAT = 8'h1C;
	localparam logic [7:0] OFF_TICK      = 8'h20;

	// field positions, widths and reset values
	localparam int         CAPABLE_BIT  = 0;
	localparam int         ERR_FLAG_BIT = 0;
	localparam int         LOCKED_BIT   = 1;
	localparam int         INJECT_BIT   = 0;
	localparam int         CTRL_W       = 5;
	localparam int         PW_W         = 8;
	localparam int         CNT_W        = 16;
	localparam logic [4:0] CTRL_RESET   = 5'h00;
	localparam logic [7:0] PW_RESET     = 8'h04;
	localparam logic [15:0] CNT_MAX     = 16'hFFFF;

	// long prbs pattern
	localparam int          PRBS_TAP_A    = 31;
	localparam int          PRBS_TAP_B    = 28;
	localparam logic [30:0] PRBS_SEED     = 31'h7FFFFFFF;
	localparam logic [5:0]  PRBS_LOCK_RUN = 6'h20;

	// test control word, bit 0 is square_wave_select
	typedef struct packed {
		logic long_prbs_check_enable;
		logic long_prbs_generate_enable;
		logic pattern_analyze_enable;
		logic pattern_generate_enable;
		logic square_wave_select;
	} test_ctrl_t;

	// one extracted overhead word from the receive framer
	typedef struct packed {
		logic       valid;
		logic       first_chan;
		logic       bip;
		logic [7:0] index;
		logic [8:0] data;
		logic [8:0] calc;
	} oh_word_t;

	// per-frame bip error pulses from the receive framer
	typedef struct packed {
		logic path;
		logic line;
		logic section;
	} bip_err_t;

	typedef enum logic [2:0] {
		OH_IDLE  = 3'b001,
		OH_PULSE = 3'b010,
		OH_SEND  = 3'b100
	} oh_state_t;

	typedef enum logic [3:0] {
		TX_OFF    = 4'b0001,
		TX_SQUARE = 4'b0010,
		TX_MIXED  = 4'b0100,
		TX_PRBS   = 4'b1000
	} tx_mode_t;

endpackage

// ### prbs31_tap.sv
// feedback tap of the long prbs polynomial over a 31-bit history
`timescale 1ns/10ps
module prbs31_tap #(
	parameter int TAP_A = 31,
	parameter int TAP_B = 28
) (
	// history, newest bit in bit 0
	input  wire logic [30:0] hist,
	// predicted next bit
	output logic             fb
);
	// x^31 + x^28 + 1
	assign fb = hist[TAP_A-1] ^ hist[TAP_B-1];
endmodule

// ### wis_oh_test.sv
// receive overhead serial port and wan test pattern generator/checker
//
// What this block does
// - each frame, shift out 231 extracted 9-bit overhead words on clock, pulse, data.
// - port clock divided from the receive clock; output valid only while in frame.
// - dummy words pad each frame so the overhead clock runs near 19.44 MHz.
// - a 0 stuff bit precedes every 9-bit word, dummies included.
// - first stuff bit appears at the first overhead clock rise after the pulse.
// - overhead is held one extra frame so path overhead goes out complete.
// - words come from the first channel, except the two line rei words.
// - bip words go out as received value xor locally calculated bip.
// - select set picks square wave, clear picks mixed; sent only with generate on.
// - square wave period follows the programmable pulse width.
// - analyze enables the receive checker; square wave traffic is never checked.
// - mixed-pattern errors accumulate in section, line and path bip counters.
// - a read-only status bit reports long prbs capability.
// - separate control bits enable the prbs generator and the prbs checker.
// - square/mixed generation beats prbs; prbs goes out only with generate clear.
// - prbs error counter saturates and clears on every read.
// - status flag is set while the prbs error counter is nonzero.
// - status bit is set while the prbs checker is locked and checking.
// - an inject request flips one generated bit; checker counts three errors.
// - line bip positions 17 to 208 go out as received xor calculated bip.
//
// The address map and the AHB-Lite slave port were decided locally.
`timescale 1ns/10ps
module wis_oh_test
	import wis_pkg::*;
(
	// clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// ahb-lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// receive framer side
	input  wire logic        rx_in_frame,
	input  wire logic        rx_frame_start,
	input  wire oh_word_t    oh_word,
	input  wire bip_err_t    rx_bip_err,
	input  wire logic        rx_test_bit,
	input  wire logic        rx_test_valid,
	// receive overhead serial port
	output logic             rx_oh_clock_out,
	output logic             rx_oh_frame_pulse_out,
	output logic             rx_oh_data_out,
	// transmit test pattern
	output logic             tx_test_bit,
	output tx_mode_t         tx_mode
);

	////////////////////////////////////////////////////////////////////////////
	// register bus

	test_ctrl_t        ctrl_reg;
	logic [PW_W-1:0]   pw_reg;
	logic              wr_pend_reg;
	logic [7:0]        wr_addr_reg;
	logic [31:0]       hrdata_reg;
	logic [31:0]       rd_mux;
	logic              rd_now;
	logic              wr_now;
	logic [7:0]        rd_addr;
	logic [CNT_W-1:0]  bip_cnt_reg [3];
	logic [CNT_W-1:0]  prbs_cnt_reg;
	logic              locked_reg;
	logic              inject_pend_reg;
	logic              inject_req;

	assign rd_now  = hsel && htrans[1] && hready && !hwrite;
	assign rd_addr = haddr[7:0];
	assign wr_now  = wr_pend_reg && (wr_addr_reg == OFF_TICK);
	assign inject_req = wr_now && hwdata[INJECT_BIT];

	// write address phase is held for the data phase; hsize is always a word
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 8'h00;
		end else if (hready) begin
			wr_pend_reg <= hsel && htrans[1] && hwrite;
			wr_addr_reg <= haddr[7:0];
		end
	end

	// control registers written in the data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_reg <= test_ctrl_t'(CTRL_RESET);
			pw_reg   <= PW_RESET;
		end else if (wr_pend_reg) begin
			if (wr_addr_reg == OFF_CTRL) begin
				ctrl_reg <= test_ctrl_t'(hwdata[CTRL_W-1:0]);
			end else if (wr_addr_reg == OFF_TXCTRL) begin
				pw_reg <= hwdata[PW_W-1:0];
			end
		end
	end

	// read decode; unmapped addresses read as zero
	always_comb begin
		rd_mux = 32'h00000000;
		if (rd_addr == OFF_CTRL) begin
			rd_mux = 32'(ctrl_reg);
		end else if (rd_addr == OFF_TXCTRL) begin
			rd_mux = 32'(pw_reg);
		end else if (rd_addr == OFF_STAT2) begin
			rd_mux[CAPABLE_BIT] = 1'b1;
		end else if (rd_addr == OFF_SECTION_BIP_ERROR_COUNT) begin
			rd_mux = 32'(bip_cnt_reg[0]);
		end else if (rd_addr == OFF_B2_CNT) begin
			rd_mux = 32'(bip_cnt_reg[1]);
		end else if (rd_addr == OFF_B3_CNT) begin
			rd_mux = 32'(bip_cnt_reg[2]);
		end else if (rd_addr == OFF_PRBS_CNT) begin
			rd_mux = 32'(prbs_cnt_reg);
		end else if (rd_addr == OFF_PRBS_STAT) begin
			rd_mux[ERR_FLAG_BIT] = (prbs_cnt_reg != 16'h0000);
			rd_mux[LOCKED_BIT]   = locked_reg;
		end
	end

	// zero wait states: read data is captured in the address phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_reg <= 32'h00000000;
		end else if (rd_now) begin
			hrdata_reg <= rd_mux;
		end
	end

	assign hrdata = hrdata_reg;

	// never stalls and never errors, so both stay constant flops
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// error counters

	logic [2:0] bip_inc;
	logic [2:0] bip_clr;
	logic       prbs_inc;
	logic       prbs_clr;

	// mixed-pattern errors only; square wave traffic is not checked
	assign bip_inc = rx_bip_err & {3{ctrl_reg.pattern_analyze_enable && !ctrl_reg.square_wave_select}};
	assign bip_clr = {rd_now && rd_addr == OFF_B3_CNT, rd_now && rd_addr == OFF_B2_CNT,
		rd_now && rd_addr == OFF_SECTION_BIP_ERROR_COUNT};
	assign prbs_clr = rd_now && rd_addr == OFF_PRBS_CNT;

	// saturating, clear on read; a hit in the clearing cycle is kept as one
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int i = 0; i < 3; i++) begin
				bip_cnt_reg[i] <= 16'h0000;
			end
		end else begin
			for (int i = 0; i < 3; i++) begin
				if (bip_inc[i]) begin
					bip_cnt_reg[i] <= bip_clr[i] ? 16'h0001 :
						(bip_cnt_reg[i] == CNT_MAX) ? CNT_MAX : bip_cnt_reg[i] + 16'h0001;
				end else if (bip_clr[i]) begin
					bip_cnt_reg[i] <= 16'h0000;
				end
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			prbs_cnt_reg <= 16'h0000;
		end else if (prbs_inc) begin
			prbs_cnt_reg <= prbs_clr ? 16'h0001 :
				(prbs_cnt_reg == CNT_MAX) ? CNT_MAX : prbs_cnt_reg + 16'h0001;
		end else if (prbs_clr) begin
			prbs_cnt_reg <= 16'h0000;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// transmit pattern generator

	tx_mode_t          tx_mode_next;
	tx_mode_t          tx_mode_reg;
	logic [PW_W-1:0]   sq_cnt_reg;
	logic              sq_level_reg;
	logic [30:0]       gen_sr_reg;
	logic              gen_fb;
	logic              tx_bit_reg;

	// square and mixed generation take priority over prbs
	always_comb begin
		tx_mode_next = TX_OFF;
		if (ctrl_reg.pattern_generate_enable) begin
			tx_mode_next = ctrl_reg.square_wave_select ? TX_SQUARE : TX_MIXED;
		end else if (ctrl_reg.long_prbs_generate_enable) begin
			tx_mode_next = TX_PRBS;
		end
	end

	// square wave toggles every max(width,1) bits
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sq_cnt_reg   <= 8'h00;
			sq_level_reg <= 1'b0;
		end else if (tx_mode_next != TX_SQUARE) begin
			sq_cnt_reg   <= 8'h00;
			sq_level_reg <= 1'b0;
		end else if ({1'b0, sq_cnt_reg} + 9'h001 >= {1'b0, pw_reg}) begin
			sq_cnt_reg   <= 8'h00;
			sq_level_reg <= !sq_level_reg;
		end else begin
			sq_cnt_reg <= sq_cnt_reg + 8'h01;
		end
	end

	prbs31_tap #(
		.TAP_A (PRBS_TAP_A),
		.TAP_B (PRBS_TAP_B)
	) u_gen_tap (
		.hist (gen_sr_reg),
		.fb   (gen_fb)
	);

	// the injected flip stays out of the register so the stream resumes clean
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			gen_sr_reg <= PRBS_SEED;
		end else if (tx_mode_next == TX_PRBS) begin
			gen_sr_reg <= {gen_sr_reg[29:0], gen_fb};
		end
	end

	// inject request waits for a prbs bit; a new request beats the clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			inject_pend_reg <= 1'b0;
		end else if (inject_req) begin
			inject_pend_reg <= 1'b1;
		end else if (tx_mode_next == TX_PRBS) begin
			inject_pend_reg <= 1'b0;
		end
	end

	// mixed frame content is built downstream; this bit idles at zero then
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tx_bit_reg  <= 1'b0;
			tx_mode_reg <= TX_OFF;
		end else begin
			tx_mode_reg <= tx_mode_next;
			case (tx_mode_next)
				TX_SQUARE: tx_bit_reg <= sq_level_reg;
				TX_PRBS:   tx_bit_reg <= gen_fb ^ inject_pend_reg;
				default:   tx_bit_reg <= 1'b0;
			endcase
		end
	end

	assign tx_test_bit = tx_bit_reg;
	assign tx_mode     = tx_mode_reg;

	////////////////////////////////////////////////////////////////////////////
	// receive prbs checker

	logic [30:0] chk_sr_reg;
	logic [5:0]  run_reg;
	logic        chk_fb;
	logic        chk_err;

	prbs31_tap #(
		.TAP_A (PRBS_TAP_A),
		.TAP_B (PRBS_TAP_B)
	) u_chk_tap (
		.hist (chk_sr_reg),
		.fb   (chk_fb)
	);

	assign chk_err  = rx_test_bit ^ chk_fb;
	assign prbs_inc = ctrl_reg.long_prbs_check_enable && rx_test_valid && locked_reg && chk_err;

	// self-seeding: one bad bit shows at the input and again at both taps
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			chk_sr_reg <= 31'h00000000;
			run_reg    <= 6'h00;
			locked_reg <= 1'b0;
		end else if (!ctrl_reg.long_prbs_check_enable) begin
			run_reg    <= 6'h00;
			locked_reg <= 1'b0;
		end else if (rx_test_valid) begin
			chk_sr_reg <= {chk_sr_reg[29:0], rx_test_bit};
			if (chk_err) begin
				run_reg <= 6'h00;
			end else if (!locked_reg) begin
				run_reg <= run_reg + 6'h01;
				locked_reg <= (run_reg + 6'h01 == PRBS_LOCK_RUN);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// overhead capture, double buffered by frame

	logic [8:0] oh_mem [2][OH_STORED];
	logic       cap_buf_reg;
	logic       cap_take;
	logic [8:0] cap_val;

	// rei words may come from another channel; all else from the first
	assign cap_take = oh_word.valid && oh_word.index < OH_STORED_IDX && (oh_word.first_chan ||
		oh_word.index == REI_STS1_IDX || oh_word.index == REI_STSN_IDX);
	assign cap_val = (oh_word.bip || (oh_word.index >= LINE_BIP_FIRST &&
		oh_word.index <= LINE_BIP_LAST)) ? oh_word.data ^ oh_word.calc : oh_word.data;

	// storage is data only, so it takes no reset
	always_ff @(posedge hclk) begin
		if (cap_take) begin
			oh_mem[cap_buf_reg][oh_word.index] <= cap_val;
		end
	end

	// each frame start hands last frame's words to the serial port
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cap_buf_reg <= 1'b0;
		end else if (rx_frame_start) begin
			cap_buf_reg <= !cap_buf_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// overhead serial port

	oh_state_t   oh_state_reg;
	logic [2:0]  div_cnt_reg;
	logic        tick_fall;
	logic        clk_out_reg;
	logic        fp_reg;
	logic        data_reg;
	logic        pend_reg;
	logic        pend_take;
	logic [7:0]  slot_reg;
	logic [3:0]  bit_cnt_reg;
	logic [8:0]  word_now;

	assign tick_fall = (div_cnt_reg == OH_DIV_LAST);
	assign pend_take = tick_fall && rx_in_frame && oh_state_reg == OH_IDLE && pend_reg;
	assign word_now  = (slot_reg < OH_STORED_IDX) ? oh_mem[!cap_buf_reg][slot_reg] : 9'h000;

	// port clock: low three cycles, high two; data moves on the fall
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			div_cnt_reg <= 3'h0;
			clk_out_reg <= 1'b0;
		end else begin
			div_cnt_reg <= tick_fall ? 3'h0 : div_cnt_reg + 3'h1;
			if (div_cnt_reg == OH_RISE_CNT) begin
				clk_out_reg <= 1'b1;
			end else if (tick_fall) begin
				clk_out_reg <= 1'b0;
			end
		end
	end

	// a frame start arriving as the last one is taken still counts
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pend_reg <= 1'b0;
		end else if (rx_frame_start) begin
			pend_reg <= 1'b1;
		end else if (pend_take) begin
			pend_reg <= 1'b0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			oh_state_reg <= OH_IDLE;
			fp_reg       <= 1'b0;
			data_reg     <= 1'b0;
			slot_reg     <= 8'h00;
			bit_cnt_reg  <= 4'h0;
		end else if (tick_fall) begin
			if (!rx_in_frame) begin
				oh_state_reg <= OH_IDLE;
				fp_reg       <= 1'b0;
				data_reg     <= 1'b0;
			end else begin
				case (oh_state_reg)
					OH_IDLE: begin
						data_reg <= 1'b0;
						if (pend_reg) begin
							fp_reg       <= 1'b1;
							oh_state_reg <= OH_PULSE;
						end
					end
					OH_PULSE: begin
						fp_reg       <= 1'b0;
						data_reg     <= 1'b0;
						slot_reg     <= 8'h00;
						bit_cnt_reg  <= 4'h1;
						oh_state_reg <= OH_SEND;
					end
					OH_SEND: begin
						if (slot_reg == OH_SLOTS) begin
							data_reg     <= 1'b0;
							oh_state_reg <= OH_IDLE;
						end else begin
							data_reg <= (bit_cnt_reg == 4'h0) ? 1'b0 : word_now[OH_LAST_BIT - bit_cnt_reg];
							if (bit_cnt_reg == OH_LAST_BIT) begin
								bit_cnt_reg <= 4'h0;
								slot_reg    <= slot_reg + 8'h01;
							end else begin
								bit_cnt_reg <= bit_cnt_reg + 4'h1;
							end
						end
					end
					default: oh_state_reg <= OH_IDLE;
				endcase
			end
		end
	end

	assign rx_oh_clock_out       = clk_out_reg;
	assign rx_oh_frame_pulse_out = fp_reg;
	assign rx_oh_data_out        = data_reg;

	////////////////////////////////////////////////////////////////////////////
	// assertions

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	property p_fp_width;
		$rose(fp_reg) |-> fp_reg[*5] ##1 !fp_reg;
	endproperty
	a_fp_width: assert property (p_fp_width) else $error("frame pulse not one port clock");

	property p_stuff_first;
		$fell(fp_reg) && rx_in_frame |-> !data_reg ##3 ($rose(clk_out_reg) && !data_reg);
	endproperty
	a_stuff_first: assert property (p_stuff_first) else $error("first stuff bit misplaced");

	property p_out_of_frame;
		$fell(rx_in_frame) |-> ##[1:6] (!fp_reg && !data_reg && oh_state_reg == OH_IDLE);
	endproperty
	a_out_of_frame: assert property (p_out_of_frame) else $error("port active out of frame");

	property p_prio;
		ctrl_reg.pattern_generate_enable |=> tx_mode_reg != TX_PRBS && tx_mode_reg != TX_OFF;
	endproperty
	a_prio: assert property (p_prio) else $error("prbs sent while generate set");

	property p_square_sel;
		ctrl_reg.pattern_generate_enable && ctrl_reg.square_wave_select |=> tx_mode_reg == TX_SQUARE;
	endproperty
	a_square_sel: assert property (p_square_sel) else $error("square wave not selected");

	property p_sat;
		prbs_cnt_reg == CNT_MAX && !prbs_clr |=> prbs_cnt_reg == CNT_MAX;
	endproperty
	a_sat: assert property (p_sat) else $error("prbs counter wrapped");

	property p_err_flag;
		rd_now && rd_addr == OFF_PRBS_STAT |=> hrdata[ERR_FLAG_BIT] == ($past(prbs_cnt_reg) != 16'h0000);
	endproperty
	a_err_flag: assert property (p_err_flag) else $error("error flag disagrees with counter");

	property p_capable;
		rd_now && rd_addr == OFF_STAT2 |=> hrdata[CAPABLE_BIT];
	endproperty
	a_capable: assert property (p_capable) else $error("prbs capability not reported");

	property p_lock_off;
		!ctrl_reg.long_prbs_check_enable |=> !locked_reg;
	endproperty
	a_lock_off: assert property (p_lock_off) else $error("locked with checker off");

	property p_bip_count;
		bip_inc[1] && !bip_clr[1] && bip_cnt_reg[1] != CNT_MAX |=> bip_cnt_reg[1] == $past(bip_cnt_reg[1]) + 16'h0001;
	endproperty
	a_bip_count: assert property (p_bip_count) else $error("line bip error not counted");

	property p_inject;
		tx_mode_next == TX_PRBS && inject_pend_reg |=> tx_bit_reg != $past(gen_fb) ##1 !inject_pend_reg;
	endproperty
	a_inject: assert property (p_inject) else $error("injected bit not flipped");

	c_frame: cover property ($fell(fp_reg) ##3 $rose(clk_out_reg));
	c_lock: cover property ($rose(locked_reg));
	c_inject: cover property (inject_pend_reg && tx_mode_next == TX_PRBS);
	c_square: cover property (tx_mode_reg == TX_SQUARE && $rose(tx_bit_reg));

endmodule

// ### oh_sink.sv
// overhead processor model: deserialises the receive overhead port
`timescale 1ns/10ps
module oh_sink (
	// serial port from the device
	input wire logic rx_oh_clock_out,
	input wire logic rx_oh_frame_pulse_out,
	input wire logic rx_oh_data_out
);
	logic [8:0] word_q [0:242];
	int         bit_n     = 2430;
	int         stuff_bad = 0;
	int         frames    = 0;
	// sample on the port clock rise; stays idle until a frame pulse is seen
	always @(posedge rx_oh_clock_out) begin
		if (rx_oh_frame_pulse_out) begin
			bit_n  <= 0;
			frames <= frames + 1;
		end else if (bit_n < 2430) begin
			if (bit_n % 10 == 0) begin
				if (rx_oh_data_out !== 1'b0) stuff_bad <= stuff_bad + 1;
			end else begin
				word_q[bit_n / 10] <= {word_q[bit_n / 10][7:0], rx_oh_data_out};
			end
			bit_n <= bit_n + 1;
		end
	end
endmodule

// ### wis_oh_test_tb.sv
// self-checking bench for the overhead port and test patterns
`timescale 1ns/10ps
module wis_oh_test_tb;
	import wis_pkg::*;
	logic        hclk = 0;
	logic        hresetn = 0;
	logic [31:0] haddr = '0;
	logic [1:0]  htrans = '0;
	logic        hwrite = 0;
	logic [31:0] hwdata = '0;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic        rx_frame_start = 0;
	logic        rx_in_frame = 1;
	oh_word_t    oh_word = '0;
	bip_err_t    rx_bip_err = '0;
	logic        rx_test_bit = 0;
	logic        rx_test_valid = 0;
	logic        oh_clk;
	logic        oh_fp;
	logic        oh_dat;
	logic        tx_test_bit;
	tx_mode_t    tx_mode;
	logic [31:0] rd;
	logic [4:0]  c;
	logic [8:0]  exp_w [0:230];
	logic        hist [0:63];
	int          failures = 0;
	int          num_checks = 0;
	int          cyc = 0;
	int          n;

	wis_oh_test dut (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .rx_in_frame(rx_in_frame), .rx_frame_start(rx_frame_start),
		.oh_word(oh_word), .rx_bip_err(rx_bip_err), .rx_test_bit(rx_test_bit),
		.rx_test_valid(rx_test_valid), .rx_oh_clock_out(oh_clk), .rx_oh_frame_pulse_out(oh_fp),
		.rx_oh_data_out(oh_dat), .tx_test_bit(tx_test_bit), .tx_mode(tx_mode));
	oh_sink sink (.rx_oh_clock_out(oh_clk), .rx_oh_frame_pulse_out(oh_fp), .rx_oh_data_out(oh_dat));

	// 100 MHz clock, loopback of the test bit, and a hang limit
	always #5 hclk = ~hclk;
	always @(posedge hclk) rx_test_bit <= tx_test_bit;
	always @(posedge hclk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			failures = failures + 1;
			wrap_up();
		end
	end

	task wrap_up;
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	// one single ahb transfer; read data lands in rd at the second ready edge
	task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		htrans <= 2'b10;
		haddr  <= {24'h0, a};
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask

	function tx_mode_t mode_of(input logic [4:0] v);
		if (v[1]) return v[0] ? TX_SQUARE : TX_MIXED;
		return v[3] ? TX_PRBS : TX_OFF;
	endfunction

	function int run_len();
		int j;
		int k;
		j = 1;
		while (hist[j] === hist[0]) j++;
		k = j + 1;
		while (hist[k] === hist[j]) k++;
		return k - j;
	endfunction

	task grab;
		for (int i = 0; i < 64; i++) begin
			@(posedge hclk);
			hist[i] = tx_test_bit;
		end
	endtask

	// bursts of bip error pulses, then read all three counters back
	task bip_run(input logic [31:0] ctl, input logic sq);
		int bc [3];
		ahb(1, OFF_CTRL, ctl);
		for (int i = 0; i < 3; i++) bc[i] = 1 + $urandom % 5;
		for (int i = 0; i < 6; i++) begin
			@(posedge hclk);
			rx_bip_err <= {i < bc[2], i < bc[1], i < bc[0]};
		end
		@(posedge hclk);
		rx_bip_err <= '0;
		for (int i = 0; i < 3; i++) begin
			ahb(0, OFF_SECTION_BIP_ERROR_COUNT + 8'(4 * i), 0);
			chk(rd, sq ? 0 : bc[i]);
		end
	endtask

	// one frame of first-channel words plus decoys from other channels
	task send_frame(input logic keep);
		oh_word_t w;
		for (int i = 0; i < 231; i++) begin
			w = '0;
			w.valid = 1;
			w.index = 8'(i);
			w.data = 9'($urandom);
			w.calc = 9'($urandom);
			w.bip = (i == 2);
			w.first_chan = !(i == 227 || i == 228);
			if (keep) exp_w[i] = (w.bip || (i >= 17 && i <= 208)) ? w.data ^ w.calc : w.data;
			@(posedge hclk);
			oh_word <= w;
			if (w.first_chan) begin
				w.first_chan = 0;
				w.data = ~w.data;
				@(posedge hclk);
				oh_word <= w;
			end
		end
		@(posedge hclk);
		oh_word <= '0;
	endtask

	task fstart;
		@(posedge hclk);
		rx_frame_start <= 1;
		@(posedge hclk);
		rx_frame_start <= 0;
	endtask

	initial begin
		void'($urandom(32'h56c18584));
		repeat (8) @(posedge hclk);
		hresetn <= 1;
		// reset values, read-only capability bit, unmapped place
		ahb(0, OFF_CTRL, 0);
		chk(rd, 32'(CTRL_RESET));
		ahb(0, OFF_TXCTRL, 0);
		chk(rd, 32'(PW_RESET));
		ahb(1, OFF_STAT2, 0);
		ahb(0, OFF_STAT2, 0);
		chk(rd, 32'h1);
		ahb(0, 8'h40, 0);
		chk(rd, 32'h0);
		chk(32'(hresp), 0);
		// mode priority: the corner of both generators on, then random controls
		for (int i = 0; i < 9; i++) begin
			c = (i == 0) ? 5'h0A : 5'($urandom);
			ahb(1, OFF_CTRL, 32'(c));
			ahb(0, OFF_CTRL, 0);
			chk(rd, 32'(c));
			chk(32'(tx_mode), 32'(mode_of(c)));
		end
		// square wave half period follows the pulse width
		n = 2 + $urandom % 8;
		ahb(1, OFF_TXCTRL, n);
		ahb(1, OFF_CTRL, 32'h03);
		grab();
		chk(32'(run_len()), 32'(n));
		// long prbs looped back: polynomial, lock, inject, counter clear
		ahb(1, OFF_CTRL, 0);
		rx_test_valid <= 1;
		ahb(1, OFF_CTRL, 32'h18);
		grab();
		for (int i = 32; i < 64; i++) chk(32'(hist[i]), 32'(hist[i - 31] ^ hist[i - 28]));
		repeat (100) @(posedge hclk);
		ahb(0, OFF_PRBS_CNT, 0);
		chk(rd, 32'h0);
		ahb(0, OFF_PRBS_STAT, 0);
		chk(rd, 32'h2);
		ahb(1, OFF_TICK, 32'h1);
		repeat (100) @(posedge hclk);
		ahb(0, OFF_PRBS_STAT, 0);
		chk(rd, 32'h3);
		ahb(0, OFF_PRBS_CNT, 0);
		chk(rd, 32'h3);
		ahb(0, OFF_PRBS_CNT, 0);
		chk(rd, 32'h0);
		bip_run(32'h04, 0);
		bip_run(32'h05, 1);
		// overhead port: frame A goes out after the next start while B arrives
		fstart();
		send_frame(1);
		repeat (12400) @(posedge hclk);
		fstart();
		send_frame(0);
		repeat (12400) @(posedge hclk);
		for (int i = 0; i < 243; i++) chk(32'(sink.word_q[i]), i < 231 ? 32'(exp_w[i]) : 0);
		chk(sink.stuff_bad, 0);
		chk(sink.frames, 2);
		// loss of frame mid-frame: port goes quiet and the cut frame is not resumed
		fstart();
		repeat (200) @(posedge hclk);
		rx_in_frame <= 0;
		repeat (20) @(posedge hclk);
		chk({oh_fp, oh_dat}, 0);
		rx_in_frame <= 1;
		repeat (50) @(posedge hclk);
		chk(sink.frames, 3);
		chk(32'(oh_fp), 0);
		wrap_up();
	end
endmodule
